/* File: rtl/keypad_scan_pkg.sv */
// Constants, register map and types shared by the keypad scanner files
package keypad_scan_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_COLUMN_ENABLE = 8'h60;
    localparam logic [7:0] ADDR_ROW_ENABLE_HIGH = 8'h61;
    localparam logic [7:0] ADDR_ROW_ENABLE_LOW = 8'h62;
    localparam logic [7:0] ADDR_CONTROL_HIGH = 8'h63;
    localparam logic [7:0] ADDR_CONTROL_LOW = 8'h64;
    localparam logic [7:0] ADDR_KEY_DATA_FIRST = 8'h68;
    localparam logic [7:0] ADDR_KEY_DATA_SECOND = 8'h69;
    localparam logic [7:0] ADDR_KEY_DATA_DEDICATED = 8'h6a;

    // Reset values
    localparam logic [7:0] COLUMN_ENABLE_RST = 8'h00;
    localparam logic [7:0] ROW_ENABLE_HIGH_RST = 8'hc0;
    localparam logic [7:0] ROW_ENABLE_LOW_RST = 8'h00;
    localparam logic [7:0] CONTROL_HIGH_RST = 8'h00;
    localparam logic [7:0] CONTROL_LOW_RST = 8'h00;
    localparam logic [7:0] KEY_BYTE_RST = 8'hf8;
    localparam logic [7:0] DEDICATED_RST = 8'h0f;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Geometry and field positions
    localparam int NUM_ROWS = 12;
    localparam int NUM_COLS = 8;
    localparam int NUM_DKEYS = 4;
    localparam int ROW_W = 4;
    localparam int COL_W = 3;
    localparam int SLOT_W = 8;
    localparam int KEY_STATE_W = 2 * SLOT_W + NUM_DKEYS;
    localparam int SET_W = 24;
    localparam int SCAN_BIT = 0;
    localparam int DEBOUNCE_LSB = 1;
    localparam int DEBOUNCE_W = 7;
    localparam int SCAN_COUNT_LSB = 4;
    localparam int SCAN_COUNT_W = 4;
    localparam logic [3:0] NO_KEY_ROW = 4'hf;
    localparam logic [3:0] LAST_ROW = 4'hb;
    localparam logic [3:0] DEDICATED_UNUSED = 4'h0;
    localparam logic [SLOT_W-1:0] EMPTY_SLOT = 8'h00;
    localparam logic [KEY_STATE_W-1:0] IDLE_KEY_STATE = 20'h0_000f;

    // Output queue
    localparam int QUEUE_DEPTH = 4;
    localparam int QPTR_W = 2;
    localparam int QCNT_W = 3;

    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int DEBOUNCE_STEP_MS = 1;
    localparam int DEBOUNCE_STEP_CYC = CLK_HZ / 1000 * DEBOUNCE_STEP_MS;
    localparam int ROW_DWELL_NS = 320;
    localparam int ROW_DWELL_CYC = (ROW_DWELL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [1:0] {SCAN_IDLE, SCAN_DRIVE, SCAN_NEXT, SCAN_WINDOW} scan_state_type;
endpackage : keypad_scan_pkg

/* File: rtl/key_debounce_timer.sv */
// Millisecond debounce timer, restartable, reports when the period has run out
`timescale 1ns/1ps
`default_nettype none
module key_debounce_timer #(
    parameter int STEP_CYC = keypad_scan_pkg::DEBOUNCE_STEP_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic start_i,
    input wire logic [keypad_scan_pkg::DEBOUNCE_W-1:0] period_ms_i,
    input wire logic clear_i,
    // Status
    output logic done_o
);
    localparam int SUB_W = $clog2(STEP_CYC + 1);
    localparam logic [keypad_scan_pkg::DEBOUNCE_W-1:0] DEBOUNCE_ONE = 7'h01;

    logic busy_q, busy_d;
    logic [keypad_scan_pkg::DEBOUNCE_W-1:0] ms_q, ms_d;
    logic [SUB_W-1:0] sub_q, sub_d;

    always_comb begin
        busy_d = busy_q;
        ms_d = ms_q;
        sub_d = sub_q;
        if (clear_i) begin
            busy_d = 1'b0;
            sub_d = '0;
        end else if (start_i) begin
            busy_d = (period_ms_i != '0);
            ms_d = period_ms_i;
            sub_d = '0;
        end else if (busy_q) begin
            if (sub_q == SUB_W'(STEP_CYC - 1)) begin
                sub_d = '0;
                ms_d = ms_q - 1'b1;
                if (ms_q == DEBOUNCE_ONE) begin
                    busy_d = 1'b0;
                end
            end else begin
                sub_d = sub_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_q <= 1'b0;
            ms_q <= '0;
            sub_q <= '0;
        end else begin
            busy_q <= busy_d;
            ms_q <= ms_d;
            sub_q <= sub_d;
        end
    end

    assign done_o = !busy_q;
endmodule : key_debounce_timer
`default_nettype wire

/* File: rtl/key_set_queue.sv */
// Four-entry queue of key data sets with overflow refusal
`timescale 1ns/1ps
`default_nettype none
module key_set_queue (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Fill side
    input wire logic push_i,
    input wire logic [keypad_scan_pkg::SET_W-1:0] data_i,
    // Drain side
    input wire logic pop_i,
    output logic [keypad_scan_pkg::SET_W-1:0] head_o,
    output logic empty_o,
    output logic full_o,
    output logic [keypad_scan_pkg::QCNT_W-1:0] level_o,
    // Events
    output logic loaded_o,
    output logic overflow_o
);
    localparam int QCNT_W = keypad_scan_pkg::QCNT_W;

    logic [keypad_scan_pkg::SET_W-1:0] mem_q [keypad_scan_pkg::QUEUE_DEPTH];
    logic [keypad_scan_pkg::QPTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [keypad_scan_pkg::QCNT_W-1:0] cnt_q, cnt_d;
    logic loaded_q, loaded_d, ovf_q, ovf_d;
    logic do_push, do_pop;

    always_comb begin
        do_push = push_i && !full_o;
        do_pop = pop_i && !empty_o;
        wr_d = do_push ? wr_q + 1'b1 : wr_q;
        rd_d = do_pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q;
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - 1'b1;
        end
        loaded_d = do_push;
        // A full queue keeps its contents and turns the new set away
        ovf_d = push_i && full_o; // RQ17
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            loaded_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            loaded_q <= loaded_d;
            ovf_q <= ovf_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= data_i;
        end
    end

    assign head_o = mem_q[rd_q];
    assign empty_o = (cnt_q == '0);
    assign full_o = (cnt_q == QCNT_W'(keypad_scan_pkg::QUEUE_DEPTH));
    assign level_o = cnt_q;
    assign loaded_o = loaded_q;
    assign overflow_o = ovf_q;
endmodule : key_set_queue
`default_nettype wire

/* File: rtl/keypad_matrix_scanner.sv */
// Keypad matrix scanner: registers, row scan, debounce and key data readout
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1 - Column enable bit includes or masks column
// RQ2 - Twelve row enable bits select scanned rows
// RQ3 - Dedicated bits turn columns 0-3 into keys
// RQ4 - Scan count 1-15 sets passes per update
// RQ5 - After N passes load set, signal host
// RQ6 - Scan bit starts and stops scanning
// RQ7 - Keypad runs only while clock enable set
// RQ8 - Host configures everything before setting scan
// RQ9 - Host pulls up columns, rows float
// RQ10 - Matrix byte: state, row, column fields
// RQ11 - Empty matrix byte carries all-ones row
// RQ12 - Dedicated byte: keys low nibble, upper zero
// RQ13 - Host keeps pulse width bits at ones
// RQ14 - Reading last byte removes the set
// RQ15 - Changes confirmed only after debounce period
// RQ16 - One enabled row low, others high
// RQ17 - Four-set queue, overflow refuses new sets
// RQ18 - Set is three bytes with dedicated keys
module keypad_matrix_scanner #(
    parameter int DEBOUNCE_STEP_CYC = keypad_scan_pkg::DEBOUNCE_STEP_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // System control
    input wire logic keypad_clock_enable_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [7:0] reg_rdata_o,
    // Matrix pins
    output logic [keypad_scan_pkg::NUM_ROWS-1:0] row_out_o,
    output logic [keypad_scan_pkg::NUM_ROWS-1:0] row_oe_o,
    input wire logic [keypad_scan_pkg::NUM_COLS-1:0] column_i,
    // Events
    output logic set_loaded_o,
    output logic overflow_o
);
    localparam int NR = keypad_scan_pkg::NUM_ROWS;
    localparam int NC = keypad_scan_pkg::NUM_COLS;
    localparam int ND = keypad_scan_pkg::NUM_DKEYS;
    localparam int SW = keypad_scan_pkg::SLOT_W;
    localparam int KW = keypad_scan_pkg::KEY_STATE_W;
    localparam int DW = $clog2(keypad_scan_pkg::ROW_DWELL_CYC + 1);
    localparam logic [DW-1:0] DWELL_LAST = DW'(keypad_scan_pkg::ROW_DWELL_CYC - 1);
    localparam logic [NR-1:0] ONE_ROW = 12'h001;
    localparam logic [NR-1:0] ALL_HIGH = 12'hfff;

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] col_en_q, col_en_d, row_hi_q, row_hi_d, row_lo_q, row_lo_d;
    logic [7:0] ctl_hi_q, ctl_hi_d, ctl_lo_q, ctl_lo_d, rdata_q, rdata_d;
    logic [keypad_scan_pkg::SET_W-1:0] head;
    logic q_empty, q_full, pop, push;
    logic [keypad_scan_pkg::QCNT_W-1:0] q_level;
    logic [NR-1:0] row_en;
    logic [NC-1:0] scan_cols;
    logic [ND-1:0] dkey_en;
    logic [keypad_scan_pkg::SCAN_COUNT_W-1:0] scan_count, count_eff;
    logic [keypad_scan_pkg::DEBOUNCE_W-1:0] debounce_time;
    logic run;

    assign row_en = {row_hi_q[ND-1:0], row_lo_q}; // RQ2
    assign dkey_en = ctl_hi_q[ND-1:0];
    assign scan_cols = col_en_q & ~{{(NC - ND){1'b0}}, dkey_en}; // RQ1 RQ3
    assign scan_count = ctl_hi_q[keypad_scan_pkg::SCAN_COUNT_LSB +: keypad_scan_pkg::SCAN_COUNT_W]; // RQ4
    assign count_eff = (scan_count == '0) ? 4'h1 : scan_count;
    assign debounce_time = ctl_lo_q[keypad_scan_pkg::DEBOUNCE_LSB +: keypad_scan_pkg::DEBOUNCE_W];
    assign run = keypad_clock_enable_i && ctl_lo_q[keypad_scan_pkg::SCAN_BIT]; // RQ6 RQ7

    always_comb begin
        col_en_d = col_en_q;
        row_hi_d = row_hi_q;
        row_lo_d = row_lo_q;
        ctl_hi_d = ctl_hi_q;
        ctl_lo_d = ctl_lo_q;
        rdata_d = rdata_q;
        pop = 1'b0;
        if (reg_write_i) begin
            if (reg_addr_i == keypad_scan_pkg::ADDR_COLUMN_ENABLE) begin
                col_en_d = reg_wdata_i;
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_ROW_ENABLE_HIGH) begin
                row_hi_d = reg_wdata_i;
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_ROW_ENABLE_LOW) begin
                row_lo_d = reg_wdata_i;
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_CONTROL_HIGH) begin
                ctl_hi_d = reg_wdata_i;
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_CONTROL_LOW) begin
                ctl_lo_d = reg_wdata_i;
            end
        end
        if (reg_read_i) begin
            // Write-only and unmapped addresses read as zero
            rdata_d = keypad_scan_pkg::UNMAPPED_READ;
            if (reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_FIRST) begin
                rdata_d = q_empty ? keypad_scan_pkg::KEY_BYTE_RST : head[23:16]; // RQ10 RQ11
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_SECOND) begin
                rdata_d = q_empty ? keypad_scan_pkg::KEY_BYTE_RST : head[15:8]; // RQ10 RQ11
                pop = (dkey_en == '0); // RQ14 RQ18
            end else if (reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_DEDICATED) begin
                rdata_d = q_empty ? keypad_scan_pkg::DEDICATED_RST : head[7:0]; // RQ12
                pop = (dkey_en != '0); // RQ14 RQ18
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            col_en_q <= keypad_scan_pkg::COLUMN_ENABLE_RST;
            row_hi_q <= keypad_scan_pkg::ROW_ENABLE_HIGH_RST;
            row_lo_q <= keypad_scan_pkg::ROW_ENABLE_LOW_RST;
            ctl_hi_q <= keypad_scan_pkg::CONTROL_HIGH_RST;
            ctl_lo_q <= keypad_scan_pkg::CONTROL_LOW_RST;
            rdata_q <= keypad_scan_pkg::UNMAPPED_READ;
        end else begin
            col_en_q <= col_en_d;
            row_hi_q <= row_hi_d;
            row_lo_q <= row_lo_d;
            ctl_hi_q <= ctl_hi_d;
            ctl_lo_q <= ctl_lo_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Row scan, key capture and debounce
    keypad_scan_pkg::scan_state_type state_q, state_d;
    logic [3:0] row_q, row_d, pass_q, pass_d;
    logic [DW-1:0] dwell_q, dwell_d;
    logic [2*SW-1:0] snap_q, snap_d;
    logic [KW-1:0] pend_q, pend_d, conf_q, conf_d, window_state;
    logic [NR-1:0] row_out_q, row_out_d, row_oe_q, row_oe_d;
    logic [ND-1:0] dkey_now;
    logic deb_start, deb_done;
    logic [SW-1:0] slot_new;
    logic [keypad_scan_pkg::SET_W-1:0] set_data;

    for (genvar g = 0; g < ND; g++) begin : g_dkey
        // Disabled dedicated keys always read as released
        assign dkey_now[g] = dkey_en[g] ? column_i[g] : 1'b1; // RQ3
    end

    assign window_state = {snap_q, dkey_now};

    always_comb begin
        slot_new = keypad_scan_pkg::EMPTY_SLOT;
        state_d = state_q;
        row_d = row_q;
        pass_d = pass_q;
        dwell_d = dwell_q;
        snap_d = snap_q;
        pend_d = pend_q;
        conf_d = conf_q;
        deb_start = 1'b0;
        push = 1'b0;
        if (!run) begin
            state_d = keypad_scan_pkg::SCAN_IDLE; // RQ6 RQ7
            row_d = '0;
            pass_d = '0;
            dwell_d = '0;
            snap_d = '0;
            pend_d = keypad_scan_pkg::IDLE_KEY_STATE;
            conf_d = keypad_scan_pkg::IDLE_KEY_STATE;
        end else begin
            case (state_q)
                keypad_scan_pkg::SCAN_IDLE: begin
                    state_d = keypad_scan_pkg::SCAN_DRIVE;
                    row_d = '0;
                    dwell_d = '0;
                end
                keypad_scan_pkg::SCAN_DRIVE: begin
                    if (!row_en[row_q]) begin
                        state_d = keypad_scan_pkg::SCAN_NEXT; // RQ2
                    end else if (dwell_q == DWELL_LAST) begin
                        // Keep at most two distinct matrix keys per window
                        for (int c = 0; c < NC; c++) begin
                            if (scan_cols[c] && !column_i[c]) begin // RQ1 RQ16
                                slot_new = {1'b1, row_q, c[2:0]};
                                if (!snap_d[SW-1]) begin
                                    snap_d[SW-1:0] = slot_new; // RQ5
                                end else if (snap_d[SW-1:0] != slot_new && !snap_d[2*SW-1]) begin
                                    snap_d[2*SW-1:SW] = slot_new; // RQ5
                                end
                            end
                        end
                        state_d = keypad_scan_pkg::SCAN_NEXT;
                    end else begin
                        dwell_d = dwell_q + 1'b1;
                    end
                end
                keypad_scan_pkg::SCAN_NEXT: begin
                    dwell_d = '0;
                    state_d = keypad_scan_pkg::SCAN_DRIVE;
                    if (row_q == keypad_scan_pkg::LAST_ROW) begin
                        row_d = '0;
                        if (pass_q + 1'b1 >= count_eff) begin
                            state_d = keypad_scan_pkg::SCAN_WINDOW; // RQ4
                        end else begin
                            pass_d = pass_q + 1'b1;
                        end
                    end else begin
                        row_d = row_q + 1'b1;
                    end
                end
                keypad_scan_pkg::SCAN_WINDOW: begin
                    // A changed window restarts the debounce period
                    if (window_state != pend_q) begin
                        pend_d = window_state; // RQ15
                        deb_start = 1'b1; // RQ15
                    end
                    snap_d = '0;
                    pass_d = '0;
                    state_d = keypad_scan_pkg::SCAN_DRIVE;
                end
                default: begin
                    state_d = keypad_scan_pkg::SCAN_IDLE;
                end
            endcase
            if (deb_done && !deb_start && pend_q != conf_q) begin
                push = 1'b1; // RQ5 RQ15
                conf_d = pend_q;
            end
        end
        row_oe_d = run ? row_en : '0; // RQ2 RQ7
        row_out_d = ALL_HIGH;
        if (run && state_d == keypad_scan_pkg::SCAN_DRIVE) begin
            row_out_d = ~(ONE_ROW << row_d); // RQ16
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= keypad_scan_pkg::SCAN_IDLE;
            row_q <= '0;
            pass_q <= '0;
            dwell_q <= '0;
            snap_q <= '0;
            pend_q <= keypad_scan_pkg::IDLE_KEY_STATE;
            conf_q <= keypad_scan_pkg::IDLE_KEY_STATE;
            row_out_q <= ALL_HIGH;
            row_oe_q <= '0;
        end else begin
            state_q <= state_d;
            row_q <= row_d;
            pass_q <= pass_d;
            dwell_q <= dwell_d;
            snap_q <= snap_d;
            pend_q <= pend_d;
            conf_q <= conf_d;
            row_out_q <= row_out_d;
            row_oe_q <= row_oe_d;
        end
    end

    assign row_out_o = row_out_q;
    assign row_oe_o = row_oe_q;

    // Present keys report down, a key that left a slot now left empty reports up
    function automatic logic [7:0] key_byte(input logic [SW-1:0] now, input logic [SW-1:0] was);
        logic [7:0] b;
        b = keypad_scan_pkg::KEY_BYTE_RST;
        if (now[SW-1]) begin
            b = {1'b0, now[SW-2:0]};
        end else if (was[SW-1]) begin
            b = {1'b1, was[SW-2:0]};
        end
        return b;
    endfunction : key_byte

    assign set_data = {key_byte(pend_q[ND +: SW], conf_q[ND +: SW]), // RQ10 RQ11
                       key_byte(pend_q[ND+SW +: SW], conf_q[ND+SW +: SW]),
                       keypad_scan_pkg::DEDICATED_UNUSED, pend_q[ND-1:0]}; // RQ12

    key_debounce_timer #(
        .STEP_CYC(DEBOUNCE_STEP_CYC)
    ) u_debounce (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .start_i(deb_start),
        .period_ms_i(debounce_time),
        .clear_i(!run),
        .done_o(deb_done)
    );

    key_set_queue u_queue (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .push_i(push),
        .data_i(set_data),
        .pop_i(pop),
        .head_o(head),
        .empty_o(q_empty),
        .full_o(q_full),
        .level_o(q_level),
        .loaded_o(set_loaded_o),
        .overflow_o(overflow_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    a_row_single_low: assert property ($countones(~row_out_o & row_oe_o) <= 1) // RQ16
        else $error("more than one row driven low");
    a_row_mask: assert property ((row_oe_o & ~$past(row_en)) == '0) // RQ2
        else $error("disabled row is driven");
    a_col_mask: assert property ($rose(snap_q[SW-1]) |-> scan_cols[snap_q[2:0]]) // RQ1 RQ3
        else $error("captured key on masked or dedicated column");
    a_stop_idle: assert property (!run |=> state_q == keypad_scan_pkg::SCAN_IDLE && !push) // RQ6
        else $error("scanner active while stopped");
    a_gate_rows: assert property (!keypad_clock_enable_i |=> row_oe_o == '0) // RQ7
        else $error("rows driven without keypad clock");
    a_window_count: assert property (state_q == keypad_scan_pkg::SCAN_WINDOW |-> $past(pass_q) + 1 == count_eff) // RQ4
        else $error("window closed at wrong pass");
    a_load_signal: assert property (push && !q_full |=> set_loaded_o && q_level == $past(q_level) + 1 - $past(pop && !q_empty)) // RQ5
        else $error("pushed set not loaded");
    a_overflow_keep: assert property (push && q_full && !pop |=> overflow_o && !set_loaded_o && q_full) // RQ17
        else $error("full queue accepted a set");
    a_push_debounced: assert property (push |-> deb_done && (pend_q == $past(pend_q) || debounce_time == '0)) // RQ15
        else $error("set pushed before debounce");
    a_empty_no_key: assert property (reg_read_i && reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_FIRST && q_empty
        |=> reg_rdata_o[6:3] == keypad_scan_pkg::NO_KEY_ROW) // RQ11
        else $error("empty key byte lacks all-ones row");
    a_first_byte: assert property (reg_read_i && reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_FIRST && !q_empty
        |=> reg_rdata_o == $past(head[23:16])) // RQ10
        else $error("first key byte mismatch");
    a_ded_upper: assert property (reg_read_i && reg_addr_i == keypad_scan_pkg::ADDR_KEY_DATA_DEDICATED
        |=> reg_rdata_o[7:4] == 4'h0) // RQ12
        else $error("dedicated byte upper bits not zero");
    a_pop_last: assert property (pop && !q_empty && !push |=> q_level == $past(q_level) - 1) // RQ14 RQ18
        else $error("last byte read did not remove set");

    c_window: cover property (state_q == keypad_scan_pkg::SCAN_WINDOW && deb_start);
    c_loaded: cover property (set_loaded_o);
    c_overflow: cover property (overflow_o);
    c_pop: cover property (pop && !q_empty);
endmodule : keypad_matrix_scanner
`default_nettype wire

/* File: dv/key_switch_model.sv */
// Behavioural key switch matrix and dedicated keys driving the column inputs
`timescale 1ns/1ps
`default_nettype none
module key_switch_model (
    // Row pins
    input wire logic [11:0] row_out_i,
    input wire logic [11:0] row_oe_i,
    // Key actuation
    input wire logic press_i,
    input wire logic [3:0] press_row_i,
    input wire logic [2:0] press_col_i,
    input wire logic [3:0] dkey_down_i,
    // Column pins
    output logic [7:0] column_o
);
    always_comb begin
        column_o = 8'hff;
        if (press_i && row_oe_i[press_row_i] && !row_out_i[press_row_i]) begin
            column_o[press_col_i] = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            if (dkey_down_i[k]) begin
                column_o[k] = 1'b0;
            end
        end
    end
endmodule : key_switch_model
`default_nettype wire

/* File: dv/test_keypad_matrix_scanner.sv */
// Register-level testbench of the keypad matrix scanner
`timescale 1ns/1ps
`default_nettype none
module test_keypad_matrix_scanner;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic kce = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [11:0] row_out;
    logic [11:0] row_oe;
    logic [7:0] column;
    logic loaded;
    logic ovf;
    logic press = 1'b0;
    logic [3:0] dkey_down = 4'h0;
    int n_mismatch = 0;
    int checks_done = 0;
    always #10 sys_clk = ~sys_clk;
    keypad_matrix_scanner #(.DEBOUNCE_STEP_CYC(10)) keypad_matrix_scanner_inst (.sys_clk_i(sys_clk),
        .resetn_i(resetn), .keypad_clock_enable_i(kce), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .row_out_o(row_out), .row_oe_o(row_oe),
        .column_i(column), .set_loaded_o(loaded), .overflow_o(ovf));
    key_switch_model key_switch_model_inst (.row_out_i(row_out), .row_oe_i(row_oe), .press_i(press),
        .press_row_i(4'h2), .press_col_i(3'h5), .dkey_down_i(dkey_down), .column_o(column));
    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        check_val({4'h0, rdata}, {4'h0, exp});
    endtask : reg_rd
    // Waits a bounded time for a set load or an overflow pulse
    task automatic wait_event(input logic want_ovf);
        int n;
        n = 0;
        while (((want_ovf ? ovf : loaded) !== 1'b1) && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        check_val({11'h000, n < 3000}, 12'h001);
        if (n >= 3000) begin
            tally_and_finish();
        end
        @(negedge sys_clk);
    endtask : wait_event
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
        reg_rd(8'h68, 8'hf8);
        reg_rd(8'h69, 8'hf8);
        reg_rd(8'h6a, 8'h0f);
        reg_rd(8'h61, 8'h00);
        reg_rd(8'h70, 8'h00);
        $display("test reset_values done");
        reg_wr(8'h60, 8'hff);
        reg_wr(8'h62, 8'hff);
        reg_wr(8'h61, 8'hcf);
        reg_wr(8'h63, 8'h10);
        @(negedge sys_clk);
        kce = 1'b1;
        reg_wr(8'h64, 8'h01);
        repeat (4) @(negedge sys_clk);
        check_val(row_oe, 12'hfff);
        press = 1'b1;
        wait_event(1'b0);
        reg_rd(8'h68, 8'h15);
        reg_rd(8'h69, 8'hf8);
        reg_rd(8'h68, 8'hf8);
        press = 1'b0;
        wait_event(1'b0);
        reg_rd(8'h68, 8'h95);
        reg_rd(8'h69, 8'hf8);
        $display("test matrix_key done");
        reg_wr(8'h64, 8'h00);
        reg_wr(8'h63, 8'h21);
        reg_wr(8'h64, 8'h05);
        for (int i = 0; i < 5; i++) begin
            dkey_down = i[0] ? 4'h0 : 4'h1;
            wait_event(i == 4);
        end
        reg_rd(8'h68, 8'hf8);
        reg_rd(8'h69, 8'hf8);
        reg_rd(8'h6a, 8'h0e);
        reg_rd(8'h6a, 8'h0f);
        $display("test dedicated_overflow done");
        kce = 1'b0;
        repeat (4) @(negedge sys_clk);
        check_val(row_oe, 12'h000);
        check_val(row_out, 12'hfff);
        $display("test clock_enable done");
        tally_and_finish();
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : test_keypad_matrix_scanner
`default_nettype wire
